// *** tb/host_model.sv ***
// host processor model: oscillator, sync and serial frames
`timescale 1ns/1ps
module host_model (
    output reg osc_in,
    output reg sync_in,
    output reg chip_select_n,
    output reg data_in,
    input wire handshake_ack
);
    reg [1:0] ph;
    initial begin
        {osc_in, sync_in, data_in, ph} = 5'h0;
        chip_select_n = 1'b1;
        #25;
        forever begin
            #1250 osc_in = 1'b1;
            ph = ph + 2'd1;
            sync_in = (ph == 2'd0);
            if (chip_select_n)
                data_in = ~data_in;
            #1250 osc_in = 1'b0;
        end
    end
    ////////////////////////////////
    task send(input [3:0] cmd, input [3:0] opr, input [79:0] dat);
        reg [88:0] f;
        integer i;
        begin
            f = {1'b1, cmd, opr, dat};
            @(posedge osc_in);
            #10;
            chip_select_n = 1'b0;
            data_in = 1'b0;
            // ack is only meaningful once its driver is enabled
            @(negedge osc_in);
            for (i = 0; i < 200 && handshake_ack !== 1'b1; i = i + 1)
                @(negedge osc_in);
            for (i = 0; i < 200 && handshake_ack !== 1'b0; i = i + 1)
                @(negedge osc_in);
            for (i = 88; i >= 0; i = i - 1) begin
                @(posedge osc_in) data_in = f[i];
                repeat (3) @(posedge osc_in);
            end
            @(posedge osc_in) chip_select_n = 1'b1;
        end
    endtask
endmodule

// *** tb/printer_if_monitor.sv ***
// port checks for the serial printer interface
`timescale 1ns/1ps
module printer_if_monitor #(
    parameter TONE_HALF = 5
) (
    input wire clk,
    input wire rst_n,
    input wire chip_select_n,
    input wire handshake_ack,
    input wire handshake_ack_oe,
    input wire [8:0] column_io_oe,
    input wire tone_out,
    input wire [2:0] aux_latched_out,
    input wire gp_mode
);
    localparam int TH1 = TONE_HALF - 1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////
    property p_ack_off;
        chip_select_n && $past(chip_select_n) |-> !handshake_ack_oe;
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("ack driven while deselected");
    property p_ack_on;
        !chip_select_n && !$past(chip_select_n) |-> handshake_ack_oe;
    endproperty
    a_ack_on: assert property (p_ack_on) else $error("ack not driven while selected");
    property p_ack_win;
        $fell(handshake_ack) && handshake_ack_oe && !chip_select_n && !gp_mode |-> !handshake_ack [*8];
    endproperty
    a_ack_win: assert property (p_ack_win) else $error("ack left low state early");
    property p_aux_hold;
        chip_select_n && $past(chip_select_n) && $past(chip_select_n, 2) |-> $stable(aux_latched_out);
    endproperty
    a_aux_hold: assert property (p_aux_hold) else $error("aux outputs moved while idle");
    property p_aux_cause;
        $changed(aux_latched_out) |-> chip_select_n;
    endproperty
    a_aux_cause: assert property (p_aux_cause) else $error("aux outputs moved mid frame");
    property p_io_off;
        !gp_mode && !$past(gp_mode) |-> column_io_oe == 9'h000;
    endproperty
    a_io_off: assert property (p_io_off) else $error("column lines driven outside io mode");
    property p_tone_hold;
        $rose(tone_out) |-> ##TH1 tone_out;
    endproperty
    a_tone_hold: assert property (p_tone_hold) else $error("tone high phase too short");
    property p_tone_flip;
        $rose(tone_out) |-> ##TONE_HALF !tone_out;
    endproperty
    a_tone_flip: assert property (p_tone_flip) else $error("tone high phase too long");
endmodule
bind serial_printer_interface printer_if_monitor #(.TONE_HALF(TONE_HALF)) mon (.*);

// *** tb/serial_printer_interface_test.sv ***
// self-checking bench for the serial printer interface
`timescale 1ns/1ps
module serial_printer_interface_test;
    localparam TONE_HALF = 5;
    localparam [79:0] COLS_VAL = 80'h1234_5678_9012_3456_7890;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg printer_timing_pulse_in = 1'b0;
    reg printer_reset_pulse_in = 1'b0;
    reg [8:0] column_in = 9'h0a5;
    reg t0;
    wire osc_in, sync_in, chip_select_n, data_in, handshake_ack, handshake_ack_oe, paper_advance_drive;
    wire second_tape_feed_drive, paper_takeup_drive, printer_motor_drive, ribbon_colour_drive, tone_out, gp_mode;
    wire [79:0] column_drive;
    wire [8:0] column_io_oe;
    wire [2:0] aux_latched_out;
    // released line has no pull: the host sees the inverse of the last value
    wire ack_line = handshake_ack_oe ? handshake_ack : ~handshake_ack;
    integer n_errors = 0;
    integer samples_checked = 0;
    serial_printer_interface #(.TONE_HALF(TONE_HALF)) dut (.*);
    host_model host (
        .osc_in(osc_in),
        .sync_in(sync_in),
        .chip_select_n(chip_select_n),
        .data_in(data_in),
        .handshake_ack(ack_line)
    );
    ////////////////////////////////
    task chk(input ok, input [8*20-1:0] msg);
        begin
            samples_checked = samples_checked + 1;
            if (ok !== 1'b1) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t %0s", $time, msg);
            end
        end
    endtask
    task timing_pulse;
        begin
            @(negedge clk) printer_timing_pulse_in = 1'b1;
            repeat (2) @(negedge clk);
            printer_timing_pulse_in = 1'b0;
        end
    endtask
    task stop_test;
        begin
            if (n_errors == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial forever #50 clk = ~clk;
    initial begin
        #8000000;
        n_errors = n_errors + 1;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        chk(handshake_ack === 1'b1 && handshake_ack_oe === 1'b0 && column_drive === 80'h0, "reset state");
        chk(aux_latched_out === 3'h0 && tone_out === 1'b0 && gp_mode === 1'b0, "reset latches");
        host.send(4'hd, 4'h0, COLS_VAL);
        repeat (4) @(negedge clk);
        chk(column_drive === COLS_VAL, "column data");
        host.send(4'hc, 4'hb, 80'h0);
        repeat (4) @(negedge clk);
        chk(aux_latched_out === 3'b101, "aux latch");
        chk(column_drive === COLS_VAL, "columns kept");
        t0 = tone_out;
        repeat (TONE_HALF) @(negedge clk);
        chk((t0 === 1'b0 || t0 === 1'b1) && tone_out === ~t0, "tone toggle");
        repeat (3000) @(negedge clk);
        chk(aux_latched_out === 3'b101 && column_drive === COLS_VAL, "idle hold");
        host.send(4'h7, 4'h0, 80'h0);
        repeat (4) @(negedge clk);
        chk(ribbon_colour_drive === 1'b1, "red ribbon");
        chk(printer_motor_drive === 1'b1, "overprint motor");
        chk(paper_advance_drive === 1'b0 && second_tape_feed_drive === 1'b0, "overprint no feed");
        host.send(4'h8, 4'h5, 80'h0);
        repeat (4) @(negedge clk);
        chk(paper_advance_drive === 1'b1 && second_tape_feed_drive === 1'b1, "feed both tapes");
        chk(paper_takeup_drive === 1'b1 && printer_motor_drive === 1'b1, "feed motor on");
        timing_pulse;
        repeat (1000) @(negedge clk);
        chk(printer_motor_drive === 1'b1, "feed line one");
        timing_pulse;
        repeat (4) @(negedge clk);
        chk(printer_motor_drive === 1'b0 && paper_takeup_drive === 1'b0, "feed line two");
        stop_test;
    end
endmodule

// *** verilog/printer_if_defines.vh ***
// constants for the serial printer interface
`ifndef PRINTER_IF_DEFINES_VH
`define PRINTER_IF_DEFINES_VH
`define OSC_PER_BIT 2'd3
`define BIT_HZ 100000
`define TONE_HZ 1000
`define CLK_HZ 10000000
`define TONE_HALF_CYCLES ((`CLK_HZ / `TONE_HZ) / 2)
`define FRAME_BITS 7'd88
`define CMD_MSB 87
`define OPER_MSB 83
`define DATA_MSB 79
`define WINDOW_BITS 3'd4
`define WAIT_BITS 6'd36
`define OP_READ 4'he
`define OP_RESET 4'hf
`define OP_LOAD_OPER 4'hc
`define OP_LOAD_DATA 4'hd
`define OP_TONE_ON_BIT 0
`define FEED_CNT_W 4
`define BUSY_BITS 4'd8
`endif

// *** verilog/serial_printer_interface.v ***
// serial printer interface: command receiver and printer output drivers
//
// How it works
// R1: bit clock derived from 400 kHz oscillator qualified by processor sync, 100 kHz.
// R2: link signals change on oscillator rise and are sampled on its fall.
// R3: processor holds chip select low for the whole exchange.
// R4: acknowledge driven only while selected, released otherwise.
// R5: acknowledge high when ready, low while busy.
// R6: twenty column outputs driven from the twenty received BCD digits.
// R7: 1 kHz square tone on auxiliary bit zero under command control.
// R8: other three auxiliary outputs are latched until reloaded.
// R9: auxiliary outputs change only from received command and operand; feed, take-up and motor outputs also drop on a printer reset pulse.
// R10: separate ribbon colour, paper feed and take-up outputs.
// R11: two independent paper feed outputs for dual-tape printers.
// R12: multiple paper feed of up to 15 lines by command.
// R13: feed may be inhibited after printing to overprint.
// R14: printer timing and reset pulses synchronise feed and motor drive.
// R15: general I/O mode: ten column outputs, nine bidirectional column lines.
// R16: general I/O mode: acknowledge line carries serial data out.
// R17: processor waits for a four-bit low window, 1 to 36 bits.
// R18: processor sends start bit, command, operand and up to 80 data bits.
// R19: after start bit shift in 88 bits, drop acknowledge, then execute.
// R20: decode print, feed, read, reset, load operand and load data commands.
// R21: power-up clears latches and shift state, acknowledge ready.
// R22: while deselected the data line is ignored; a pending command executes there and feed, pulses and tone still act.
`timescale 1ns/1ps
`include "printer_if_defines.vh"
module serial_printer_interface #(
    parameter COLS = 20,
    parameter TONE_HALF = `TONE_HALF_CYCLES
) (
    input wire clk,
    input wire rst_n,
    input wire osc_in,
    input wire sync_in,
    input wire chip_select_n,
    input wire data_in,
    input wire printer_timing_pulse_in,
    input wire printer_reset_pulse_in,
    input wire [8:0] column_in,
    output reg handshake_ack,
    output reg handshake_ack_oe,
    output reg [COLS*4-1:0] column_drive,
    output reg [8:0] column_io_oe,
    output reg paper_advance_drive,
    output reg second_tape_feed_drive,
    output reg paper_takeup_drive,
    output reg printer_motor_drive,
    output reg ribbon_colour_drive,
    output reg tone_out,
    output reg [2:0] aux_latched_out,
    output reg gp_mode
);
////////////////////////////////////////////////////////////////////////
// oscillator edges and bit clock
reg osc_reg;
reg sync_reg;
reg [1:0] phase_reg;
reg [3:0] oper_reg;
reg [87:0] shift_reg;
reg [6:0] count_reg;
reg [5:0] wait_reg;
reg [1:0] state_reg;
reg [3:0] feed_cnt_reg;
reg [3:0] busy_reg;
reg pend_reg;
reg tone_en_reg;
reg [15:0] tone_cnt_reg;
reg [8:0] read_sh_reg;
reg tp_reg;
reg tr_reg;
localparam S_WINDOW = 2'd0;
localparam S_START = 2'd1;
localparam S_SHIFT = 2'd2;
localparam S_BUSY = 2'd3;
wire osc_fall = osc_reg & ~osc_in; // R2
wire bit_tick = osc_fall & (phase_reg == `OSC_PER_BIT); // R1
wire selected = ~chip_select_n;
wire tp_rise = printer_timing_pulse_in & ~tp_reg;
wire tr_rise = printer_reset_pulse_in & ~tr_reg;
// busy period over: executed, busy count run out and no feed line pending
wire frame_done = (state_reg == S_BUSY) && !pend_reg && (busy_reg == 4'd0) && (feed_cnt_reg == 4'd0);
wire [3:0] rx_cmd = shift_reg[`CMD_MSB -: 4];
wire [3:0] rx_oper = shift_reg[`OPER_MSB -: 4];
// decode feed operand into line count
function [3:0] feed_lines;
    input [3:0] code;
    begin
        case (code)
            4'h8: feed_lines = 4'hf;
            4'hc: feed_lines = 4'he;
            4'ha: feed_lines = 4'hd;
            4'h7: feed_lines = 4'hc;
            4'h4: feed_lines = 4'hb;
            4'h6: feed_lines = 4'ha;
            4'hd: feed_lines = 4'h9;
            4'h3: feed_lines = 4'h8;
            4'h2: feed_lines = 4'h7;
            4'hb: feed_lines = 4'h6;
            4'he: feed_lines = 4'h5;
            4'h1: feed_lines = 4'h4;
            4'h9: feed_lines = 4'h3;
            4'h5: feed_lines = 4'h2;
            default: feed_lines = 4'h1;
        endcase
    end
endfunction
////////////////////////////////////////////////////////////////////////
// receiver and command execution
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        osc_reg <= 1'b0;
        sync_reg <= 1'b0;
        phase_reg <= 2'd0;
        shift_reg <= 88'h0; // R21
        count_reg <= 7'd0;
        wait_reg <= 6'd0;
        state_reg <= S_WINDOW;
        feed_cnt_reg <= 4'd0;
        busy_reg <= 4'd0;
        pend_reg <= 1'b0;
        oper_reg <= 4'h0;
        tone_en_reg <= 1'b0;
        read_sh_reg <= 9'h0;
        tp_reg <= 1'b0;
        tr_reg <= 1'b0;
        handshake_ack <= 1'b1; // R21
        handshake_ack_oe <= 1'b0;
        column_drive <= {COLS*4{1'b0}};
        column_io_oe <= 9'h0;
        paper_advance_drive <= 1'b0;
        second_tape_feed_drive <= 1'b0;
        paper_takeup_drive <= 1'b0;
        printer_motor_drive <= 1'b0;
        ribbon_colour_drive <= 1'b0;
        aux_latched_out <= 3'h0;
        gp_mode <= 1'b0;
    end else begin
        osc_reg <= osc_in;
        sync_reg <= sync_in;
        tp_reg <= printer_timing_pulse_in;
        tr_reg <= printer_reset_pulse_in;
        handshake_ack_oe <= selected; // R4
        if (osc_fall) begin
            if (sync_reg)
                phase_reg <= 2'd0; // R1
            else
                phase_reg <= phase_reg + 2'd1;
        end
        if (!selected) begin
            // R22
            if (state_reg != S_BUSY)
                state_reg <= S_WINDOW;
            wait_reg <= 6'd0;
            handshake_ack <= (state_reg != S_BUSY);
        end else if (bit_tick) begin
            case (state_reg)
                S_WINDOW: begin
                    if (gp_mode)
                        handshake_ack <= read_sh_reg[8]; // R16
                    else
                        handshake_ack <= 1'b1; // R5
                    read_sh_reg <= {read_sh_reg[7:0], 1'b0};
                    wait_reg <= wait_reg + 6'd1;
                    if (wait_reg == `WAIT_BITS - 6'd1) begin
                        handshake_ack <= 1'b0;
                        count_reg <= 7'd0;
                        state_reg <= S_START;
                    end
                end
                S_START: begin
                    count_reg <= count_reg + 7'd1;
                    if (data_in) begin
                        count_reg <= 7'd0;
                        state_reg <= S_SHIFT;
                    end else if (count_reg == {4'd0, `WINDOW_BITS} - 7'd1) begin
                        wait_reg <= 6'd0;
                        state_reg <= S_WINDOW;
                    end
                end
                S_SHIFT: begin
                    shift_reg <= {shift_reg[86:0], data_in}; // R19
                    count_reg <= count_reg + 7'd1;
                    if (count_reg == `FRAME_BITS - 7'd1) begin
                        // one execution per received frame
                        state_reg <= S_BUSY;
                        pend_reg <= 1'b1;
                    end
                end
                default: begin
                    handshake_ack <= 1'b0; // R5
                end
            endcase
        end
        if (state_reg == S_BUSY && pend_reg && !selected) begin
            // R20
            pend_reg <= 1'b0;
            busy_reg <= `BUSY_BITS;
            if (!rx_cmd[3]) begin
                column_drive <= shift_reg[`DATA_MSB:0]; // R6
                ribbon_colour_drive <= rx_cmd[2]; // R10
                paper_advance_drive <= ~rx_cmd[1]; // R11
                second_tape_feed_drive <= ~rx_cmd[0];
                printer_motor_drive <= 1'b1;
                feed_cnt_reg <= (rx_cmd[1:0] == 2'b11) ? 4'd0 : 4'd1; // R13
            end else if (rx_cmd[3:2] == 2'b10) begin
                paper_advance_drive <= ~rx_cmd[1];
                second_tape_feed_drive <= ~rx_cmd[0];
                paper_takeup_drive <= 1'b1;
                printer_motor_drive <= 1'b1;
                feed_cnt_reg <= feed_lines(rx_oper); // R12
            end else if (rx_cmd == `OP_READ) begin
                read_sh_reg <= column_in; // R15
            end else if (rx_cmd == `OP_RESET) begin
                column_drive <= {COLS*4{1'b0}};
                aux_latched_out <= 3'h0;
                tone_en_reg <= 1'b0;
                gp_mode <= rx_oper[2];
            end else if (rx_cmd == `OP_LOAD_OPER) begin
                tone_en_reg <= rx_oper[`OP_TONE_ON_BIT]; // R7
                aux_latched_out <= rx_oper[3:1]; // R8 R9
            end else begin
                column_drive <= shift_reg[`DATA_MSB:0];
                column_io_oe <= {9{gp_mode}} & ~shift_reg[8:0]; // R15
            end
        end
        if (state_reg == S_BUSY && busy_reg != 4'd0 && bit_tick)
            busy_reg <= busy_reg - 4'd1;
        // R14
        if (tp_rise && feed_cnt_reg != 4'd0)
            feed_cnt_reg <= feed_cnt_reg - 4'd1;
        if (tr_rise || frame_done) begin
            paper_advance_drive <= 1'b0;
            second_tape_feed_drive <= 1'b0;
            paper_takeup_drive <= 1'b0;
            printer_motor_drive <= 1'b0;
        end
        if (frame_done) begin
            state_reg <= S_WINDOW;
            wait_reg <= 6'd0;
        end
    end
end
////////////////////////////////////////////////////////////////////////
// tone generator
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        tone_cnt_reg <= 16'd0;
        tone_out <= 1'b0;
    end else if (!tone_en_reg) begin
        tone_cnt_reg <= 16'd0;
        tone_out <= 1'b0;
    end else if (tone_cnt_reg == TONE_HALF[15:0] - 16'd1) begin
        tone_cnt_reg <= 16'd0;
        tone_out <= ~tone_out; // R7
    end else begin
        tone_cnt_reg <= tone_cnt_reg + 16'd1;
    end
end
endmodule
